// ### pfpwm_load.sv
// behavioural load on one pwm pin: counts the cycles it sees high in a window
// assumes pin and oe_n change only just after rising clock edges
`timescale 1ns/10ps
module pfpwm_load (
  input  wire logic        clk,      // i/o clock
  input  wire logic        pin,      // pin level from the timer
  input  wire logic        oe_n,     // low while the timer drives
  input  wire logic        start,    // begin a measuring window
  input  wire logic [15:0] win,      // window length in cycles
  output logic             done,     // one cycle at window end
  output logic [15:0]      high_cnt  // cycles seen high
);
  logic [15:0] left;
  logic        level;

  initial done = 1'h0;
  initial left = 16'h0000;
  // a released pin falls to the pull-down instead of keeping its last level
  assign level = oe_n ? 1'h0 : pin;

  always @(posedge clk) begin
    done <= 1'h0;
    if (start) begin
      left <= win;
      high_cnt <= 16'h0000;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
      high_cnt <= high_cnt + {15'h0000, level};
      done <= (left == 16'h0001);
    end
  end
endmodule

// ### pfpwm_pkg.sv
// shared constants of the dual-slope symmetric pwm timer
// assumes a single clock domain and a 32-bit axi4-lite register bus
package pfpwm_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int         ADDR_W     = 6;
  localparam logic [5:0] OFF_CTRL   = 6'h00;
  localparam logic [5:0] OFF_COUNT  = 6'h04;
  localparam logic [5:0] OFF_CMPA   = 6'h08;
  localparam logic [5:0] OFF_CMPB   = 6'h0c;
  localparam logic [5:0] OFF_CAPT   = 6'h10;
  localparam logic [5:0] OFF_STAT   = 6'h14;
  localparam logic [5:0] OFF_CLR    = 6'h18;
  localparam logic [5:0] OFF_IEN    = 6'h1c;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_CS_LSB   = 4;
  localparam int          CTRL_ACTA_LSB = 8;
  localparam int          CTRL_ACTB_LSB = 10;
  localparam int          CTRL_DIRA_BIT = 12;
  localparam int          CTRL_DIRB_BIT = 13;
  localparam int          CTRL_PRTA_BIT = 14;
  localparam int          CTRL_PRTB_BIT = 15;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;

  localparam logic [3:0]  MODE_CAPT_TOP = 4'h8;
  localparam logic [3:0]  MODE_CMPA_TOP = 4'h9;

  localparam logic [1:0]  ACT_OFF    = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE = 2'h1;
  localparam logic [1:0]  ACT_NONINV = 2'h2;
  localparam logic [1:0]  ACT_INV    = 2'h3;

  // ****************************************************************
  // status bits, prescaler selects, misc values
  // ****************************************************************
  localparam int          ST_W    = 4;
  localparam int          ST_OVF  = 0;
  localparam int          ST_CMPA = 1;
  localparam int          ST_CMPB = 2;
  localparam int          ST_CAPT = 3;

  localparam int          PRE_W      = 10;
  localparam logic [2:0]  CS_STOP    = 3'h0;
  localparam logic [2:0]  CS_DIV1    = 3'h1;
  localparam logic [2:0]  CS_DIV8    = 3'h2;
  localparam logic [2:0]  CS_DIV64   = 3'h3;
  localparam logic [2:0]  CS_DIV256  = 3'h4;
  localparam logic [2:0]  CS_DIV1024 = 3'h5;

  localparam logic [15:0] BOTTOM      = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// ### pfpwm_prescaler.sv
// prescaler producing the one-cycle timer tick enable
// assumes clk is the i/o clock and srst is synchronous, active high
`timescale 1ns/10ps
module pfpwm_prescaler
  import pfpwm_pkg::*;
#(
  parameter int DIV_W = PRE_W
) (
  input  wire logic       clk,        // i/o clock
  input  wire logic       srst,       // synchronous reset
  input  wire logic [2:0] clk_select, // divider choice
  output logic            timer_tick  // one-cycle enable
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } pfpwm_pre_t;

  pfpwm_pre_t s;
  pfpwm_pre_t next_s;

  // all-ones pattern of the low count bits marks the end of a division
  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
    case (sel)
      CS_DIV8:    div_mask = DIV_W'(10'h007);
      CS_DIV64:   div_mask = DIV_W'(10'h03f);
      CS_DIV256:  div_mask = DIV_W'(10'h0ff);
      CS_DIV1024: div_mask = DIV_W'(10'h3ff);
      default:    div_mask = '0;
    endcase
  endfunction

  always_comb begin
    next_s = s;
    if (clk_select == CS_STOP || clk_select > CS_DIV1024) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b0;
    end else begin
      next_s.cnt  = s.cnt + DIV_W'(1);
      next_s.tick = ((s.cnt & div_mask(clk_select)) == div_mask(clk_select));
    end
  end

  // the tick is an enable in the same clock domain, never a clock
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign timer_tick = s.tick;

endmodule

// ### pfpwm_timer.sv
// dual-slope symmetric pwm timer with axi4-lite registers and an interrupt
// assumes one clock CLK, synchronous active-high SRST, pins synchronous to CLK
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module pfpwm_timer
  import pfpwm_pkg::*;
(
  input  wire logic        CLK,        // i/o clock, 10 mhz
  input  wire logic        SRST,       // synchronous reset, active high
  input  wire logic [5:0]  AWADDR,     // write address
  input  wire logic        AWVALID,    // write address valid
  output logic             AWREADY,    // write address ready
  input  wire logic [31:0] WDATA,      // write data
  input  wire logic [3:0]  WSTRB,      // write byte strobes
  input  wire logic        WVALID,     // write data valid
  output logic             WREADY,     // write data ready
  output logic [1:0]       BRESP,      // write response
  output logic             BVALID,     // write response valid
  input  wire logic        BREADY,     // write response ready
  input  wire logic [5:0]  ARADDR,     // read address
  input  wire logic        ARVALID,    // read address valid
  output logic             ARREADY,    // read address ready
  output logic [31:0]      RDATA,      // read data
  output logic [1:0]       RRESP,      // read response
  output logic             RVALID,     // read data valid
  input  wire logic        RREADY,     // read data ready
  output logic             IRQ,        // level interrupt
  output logic             PIN_A,      // pin a level
  output logic             PIN_A_OE_N, // pin a driver enable, low drives
  output logic             PIN_B,      // pin b level
  output logic             PIN_B_OE_N  // pin b driver enable, low drives
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0]     ctrl;
    logic [15:0]     cmp_buf_a;
    logic [15:0]     cmp_buf_b;
    logic [15:0]     cmp_act_a;
    logic [15:0]     cmp_act_b;
    logic [15:0]     capture_top_value;
    logic [15:0]     counter_value;
    logic            count_up;
    logic            oc_a;
    logic            oc_b;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] irq_en;
    logic            irq;
    logic            pin_a;
    logic            pin_a_oe_n;
    logic            pin_b;
    logic            pin_b_oe_n;
    logic            awready;
    logic            wready;
    logic            aw_full;
    logic            w_full;
    logic [5:0]      aw_addr;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } pfpwm_state_t;

  pfpwm_state_t s;
  pfpwm_state_t next_s;
  logic         timer_tick;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // output action for one channel at one tick
  function automatic logic oc_update(input logic oc, input logic [1:0] act, input logic eff_up,
                                     input logic match, input logic toggle_ok);
    oc_update = oc;
    if (match) begin
      case (act)
        ACT_NONINV: oc_update = ~eff_up;
        ACT_INV:    oc_update = eff_up;
        ACT_TOGGLE: oc_update = toggle_ok ? ~oc : oc;
        default:    oc_update = oc;
      endcase
    end
  endfunction

  // ****************************************************************
  // prescaler
  // ****************************************************************
  pfpwm_prescaler #(
    .DIV_W (PRE_W)
  ) u_prescaler (
    .clk        (CLK),
    .srst       (SRST),
    .clk_select (s.ctrl[CTRL_CS_LSB +: 3]),
    .timer_tick (timer_tick)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [3:0]      mode;
    logic            mode_ok;
    logic [15:0]     top;
    logic            at_top;
    logic            at_bot;
    logic            eff_up;
    logic            match_a;
    logic            match_b;
    logic [ST_W-1:0] events;
    logic [ST_W-1:0] clr;
    logic [1:0]      act_a;
    logic [1:0]      act_b;
    logic            wsel;
    logic            rsel;

    next_s  = s;
    mode    = s.ctrl[CTRL_MODE_LSB +: 4];
    act_a   = s.ctrl[CTRL_ACTA_LSB +: 2];
    act_b   = s.ctrl[CTRL_ACTB_LSB +: 2];
    mode_ok = (mode == MODE_CAPT_TOP) || (mode == MODE_CMPA_TOP);
    top     = (mode == MODE_CMPA_TOP) ? s.cmp_act_a : s.capture_top_value;
    at_top  = (s.counter_value == top);
    at_bot  = (s.counter_value == BOTTOM);
    // bottom always counts as up-going and top as down-going, which keeps
    // compare-at-bottom steady low and compare-at-top steady high on a non-inverting channel
    eff_up  = at_bot ? 1'b1 : (at_top ? 1'b0 : s.count_up);
    // a compare value above top is never reached by the counter
    match_a = (s.counter_value == s.cmp_act_a);
    match_b = (s.counter_value == s.cmp_act_b);
    events  = '0;
    clr     = '0;
    wsel    = 1'b0;
    rsel    = 1'b0;

    // ****************************************************************
    // counter and waveform, advanced only on the tick enable
    // ****************************************************************
    if (timer_tick && mode_ok) begin
      if (at_bot) begin
        next_s.counter_value = (top == BOTTOM) ? BOTTOM : 16'h0001;
        next_s.count_up      = 1'b1;
        next_s.cmp_act_a     = s.cmp_buf_a;
        next_s.cmp_act_b     = s.cmp_buf_b;
        events[ST_OVF]       = 1'b1;
      end else if (at_top) begin
        // top shows for this single tick, then the count turns down
        next_s.counter_value = s.counter_value - 16'h0001;
        next_s.count_up      = 1'b0;
      end else if (s.count_up) begin
        next_s.counter_value = s.counter_value + 16'h0001;
      end else begin
        next_s.counter_value = s.counter_value - 16'h0001;
      end
      if (match_a) begin
        events[ST_CMPA] = 1'b1;
      end
      if (match_b) begin
        events[ST_CMPB] = 1'b1;
      end
      if (at_top && mode == MODE_CMPA_TOP) begin
        events[ST_CMPA] = 1'b1;
      end
      if (at_top && mode == MODE_CAPT_TOP) begin
        events[ST_CAPT] = 1'b1;
      end
      next_s.oc_a = oc_update(s.oc_a, act_a, eff_up, match_a, mode == MODE_CMPA_TOP);
      next_s.oc_b = oc_update(s.oc_b, act_b, eff_up, match_b, 1'b0);
    end

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    if (AWVALID && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = AWADDR;
    end
    if (WVALID && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.wdata  = WDATA;
      next_s.wstrb  = WSTRB;
    end
    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_full && s.w_full && !s.bvalid) begin
      wsel           = 1'b1;
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      case (s.aw_addr)
        OFF_CTRL: next_s.ctrl              = merge16(s.ctrl, s.wdata, s.wstrb);
        OFF_CMPA: next_s.cmp_buf_a         = merge16(s.cmp_buf_a, s.wdata, s.wstrb);
        OFF_CMPB: next_s.cmp_buf_b         = merge16(s.cmp_buf_b, s.wdata, s.wstrb);
        OFF_CAPT: next_s.capture_top_value = merge16(s.capture_top_value, s.wdata, s.wstrb);
        OFF_COUNT: next_s.bresp            = RESP_OKAY;
        OFF_STAT: next_s.bresp             = RESP_OKAY;
        OFF_CLR: begin
          if (s.wstrb[0]) begin
            clr = s.wdata[ST_W-1:0];
          end
        end
        OFF_IEN: begin
          if (s.wstrb[0]) begin
            next_s.irq_en = s.wdata[ST_W-1:0];
          end
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready  = !next_s.w_full && !next_s.bvalid;

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (ARVALID && s.arready) begin
      rsel          = 1'b1;
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = 32'h00000000;
      case (ARADDR)
        OFF_CTRL:  next_s.rdata[15:0]     = s.ctrl;
        OFF_COUNT: next_s.rdata[15:0]     = s.counter_value;
        OFF_CMPA:  next_s.rdata[15:0]     = s.cmp_buf_a;
        OFF_CMPB:  next_s.rdata[15:0]     = s.cmp_buf_b;
        OFF_CAPT:  next_s.rdata[15:0]     = s.capture_top_value;
        OFF_STAT:  next_s.rdata[ST_W-1:0] = s.status;
        OFF_CLR:   next_s.rdata[ST_W-1:0] = '0;
        OFF_IEN:   next_s.rdata[ST_W-1:0] = s.irq_en;
        default:   next_s.rresp           = RESP_SLVERR;
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // ****************************************************************
    // flags and interrupt
    // ****************************************************************
    // a flag event in the cycle of its clear still lands
    next_s.status = (s.status & ~clr) | events;
    next_s.irq    = |(next_s.status & next_s.irq_en);

    // ****************************************************************
    // pins
    // ****************************************************************
    // the waveform owns a pin only in a pwm mode with a live action;
    // toggle on channel b leaves the pin to the port bit
    if (mode_ok && act_a != ACT_OFF && (act_a != ACT_TOGGLE || mode == MODE_CMPA_TOP)) begin
      next_s.pin_a = next_s.oc_a;
    end else begin
      next_s.pin_a = s.ctrl[CTRL_PRTA_BIT];
    end
    if (mode_ok && (act_b == ACT_NONINV || act_b == ACT_INV)) begin
      next_s.pin_b = next_s.oc_b;
    end else begin
      next_s.pin_b = s.ctrl[CTRL_PRTB_BIT];
    end
    next_s.pin_a_oe_n = ~s.ctrl[CTRL_DIRA_BIT];
    next_s.pin_b_oe_n = ~s.ctrl[CTRL_DIRB_BIT];

    // unused selects only mark which access took effect this cycle
    if (wsel && rsel) begin
      next_s.bresp = next_s.bresp;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // zero reset except count_up and both oe_n set: bottom, counting up, pins released, flags, compares, actions cleared
  always_ff @(posedge CLK) begin
    if (SRST) begin
      s                   <= '0;
      s.ctrl              <= CTRL_RESET;
      s.counter_value     <= BOTTOM;
      s.count_up          <= 1'b1;
      s.pin_a_oe_n        <= 1'b1;
      s.pin_b_oe_n        <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs, all straight from flops
  // ****************************************************************
  assign AWREADY    = s.awready;
  assign WREADY     = s.wready;
  assign BVALID     = s.bvalid;
  assign BRESP      = s.bresp;
  assign ARREADY    = s.arready;
  assign RVALID     = s.rvalid;
  assign RDATA      = s.rdata;
  assign RRESP      = s.rresp;
  assign IRQ        = s.irq;
  assign PIN_A      = s.pin_a;
  assign PIN_A_OE_N = s.pin_a_oe_n;
  assign PIN_B      = s.pin_b;
  assign PIN_B_OE_N = s.pin_b_oe_n;

endmodule

// ### pfpwm_timer_properties.sv
// concurrent checks on the pwm timer's bus, interrupt and pin ports
// assumes one clock CLK and synchronous active-high SRST
`timescale 1ns/10ps
module pfpwm_timer_properties (
  input wire logic        CLK,        // i/o clock
  input wire logic        SRST,       // synchronous reset
  input wire logic        AWVALID,    // write address valid
  input wire logic        AWREADY,    // write address ready
  input wire logic        WVALID,     // write data valid
  input wire logic        WREADY,     // write data ready
  input wire logic [1:0]  BRESP,      // write response
  input wire logic        BVALID,     // write response valid
  input wire logic        BREADY,     // write response ready
  input wire logic        ARVALID,    // read address valid
  input wire logic        ARREADY,    // read address ready
  input wire logic [31:0] RDATA,      // read data
  input wire logic        RVALID,     // read data valid
  input wire logic        RREADY,     // read data ready
  input wire logic        IRQ,        // level interrupt
  input wire logic        PIN_A_OE_N, // pin a driver enable
  input wire logic        PIN_B_OE_N  // pin b driver enable
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // ****************************************************************
  // handshake steps
  // ****************************************************************
  sequence s_wr_take;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_rd_take;
    ARVALID && ARREADY;
  endsequence
  // ****************************************************************
  // properties
  // ****************************************************************
  a_reset_idle: assert property ($fell(SRST) |-> !IRQ && PIN_A_OE_N && PIN_B_OE_N && !BVALID && !RVALID)
    else $error("outputs not idle after reset");
  a_wr_answer: assert property (s_wr_take |-> ##2 BVALID)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_take |=> RVALID)
    else $error("read data late");
  a_b_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_r_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_b_blocks: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("new write taken while response pending");
  a_r_blocks: assert property (RVALID |-> !ARREADY)
    else $error("new read taken while data pending");
  a_upper_zero: assert property (RVALID |-> RDATA[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule

// ### test_dual_slope_symmetric_pwm.sv
// self-checking bench for the dual-slope pwm timer: bus tasks, pin loads, scoreboard
// assumes pfpwm_pkg, the timer, its checker and the load model are compiled first
`timescale 1ns/10ps
module test_dual_slope_symmetric_pwm;
  import pfpwm_pkg::*;
  // ****************************************************************
  // signals and scoreboard
  // ****************************************************************
  localparam int          TOPB  = 9;
  localparam logic [34:0] M_ALL = {2'h3, 1'h1, 32'hffffffff};
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic [5:0]  awaddr = 6'h00;
  logic [5:0]  araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h3;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        start_a = 1'h0;
  logic        start_b = 1'h0;
  logic [15:0] win = 16'h0000;
  logic        awready, wready, bvalid, arready, rvalid, irq, done_a, done_b;
  logic        pin_a, pin_a_oe_n, pin_b, pin_b_oe_n;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] cnt_a, cnt_b;
  logic [34:0] rq[$];
  logic [34:0] mq[$];
  logic [1:0]  wq[$];
  logic [15:0] pq[$];
  int          divs[5] = '{1, 8, 64, 256, 1024};
  int          n_errors = 0;
  int          checks_done = 0;
  int          seed = 32'hb1c568e8;

  always #50 clk = ~clk;

  pfpwm_timer DUT (
    .CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .IRQ(irq),
    .PIN_A(pin_a), .PIN_A_OE_N(pin_a_oe_n), .PIN_B(pin_b), .PIN_B_OE_N(pin_b_oe_n)
  );
  pfpwm_load u_load_a (.clk(clk), .pin(pin_a), .oe_n(pin_a_oe_n), .start(start_a), .win(win),
                       .done(done_a), .high_cnt(cnt_a));
  pfpwm_load u_load_b (.clk(clk), .pin(pin_b), .oe_n(pin_b_oe_n), .start(start_b), .win(win),
                       .done(done_b), .high_cnt(cnt_b));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cmp(input logic [34:0] got, input logic [34:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic hang;
    n_errors++;
    $display("ERROR t=%0t wait expired got=%h exp=%h", $time, 1'h0, 1'h1);
    close_out();
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    wq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    if (n == 50) hang();
  endtask

  task automatic rd(input logic [5:0] a, input logic [34:0] e, input logic [34:0] m);
    int n;
    rq.push_back(e & m);
    mq.push_back(m);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rready <= 1'h0;
    if (n == 50) hang();
  endtask

  // high cycles seen by the load over one window, from the pin settings
  task automatic meas(input logic b, input int w, input int e);
    int n;
    pq.push_back(e[15:0]);
    @(posedge clk);
    win <= w[15:0];
    start_a <= ~b;
    start_b <= b;
    @(posedge clk);
    start_a <= 1'h0;
    start_b <= 1'h0;
    for (n = 0; n < w + 5 && done_a !== 1'h1 && done_b !== 1'h1; n++) @(posedge clk);
    if (n == w + 5) hang();
  endtask

  function automatic int hi_b(input logic [15:0] ctrl, input int c, input int nd);
    if (ctrl[CTRL_DIRB_BIT] !== 1'h1) return 0;
    if (ctrl[CTRL_ACTB_LSB +: 2] == ACT_NONINV) return 2 * c * nd;
    if (ctrl[CTRL_ACTB_LSB +: 2] == ACT_INV) return 2 * (TOPB - c) * nd;
    return ctrl[CTRL_PRTB_BIT] ? 2 * TOPB * nd : 0;
  endfunction

  // results are taken off the queues in the order they were noted
  always @(posedge clk) begin
    if (rvalid === 1'h1 && rready === 1'h1) cmp({rresp, irq, rdata} & mq.pop_front(), rq.pop_front());
    if (bvalid === 1'h1 && bready === 1'h1) cmp({bresp, 33'h0}, {wq.pop_front(), 33'h0});
    if (done_a === 1'h1) cmp({19'h0, cnt_a}, {19'h0, pq.pop_front()});
    if (done_b === 1'h1) cmp({19'h0, cnt_b}, {19'h0, pq.pop_front()});
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    logic [15:0] ctrl;
    logic [5:0]  a;
    int          nd;
    int          c;
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    for (a = OFF_CTRL; a <= OFF_IEN; a += 6'h04) rd(a, 35'h0, M_ALL);
    rd(6'h20, {RESP_SLVERR, 33'h0}, {2'h3, 33'h0});
    wr(6'h24, 32'h1, RESP_SLVERR);
    wr(OFF_COUNT, 32'h1234, RESP_OKAY);
    rd(OFF_COUNT, 35'h0, M_ALL);
    $display("test register reset done");
    wr(OFF_CMPA, 32'h3, RESP_OKAY);
    wr(OFF_CTRL, 32'h1119, RESP_OKAY);
    idle(30);
    meas(1'h0, 120, 60);
    wr(OFF_CTRL, 32'h5319, RESP_OKAY);
    idle(30);
    meas(1'h0, 12, 0);
    wr(OFF_CTRL, 32'h5019, RESP_OKAY);
    idle(4);
    meas(1'h0, 12, 12);
    $display("test toggle done");
    wr(OFF_CAPT, 32'(TOPB), RESP_OKAY);
    rd(OFF_CAPT, 35'(TOPB), M_ALL);
    for (int i = 0; i < 10; i++) begin
      nd = (i < 5) ? divs[i] : 1;
      c = (i == 6) ? TOPB : (i == 7) ? 0 : $unsigned($random(seed)) % (TOPB + 1);
      ctrl = 16'h0000;
      ctrl[CTRL_MODE_LSB +: 4] = MODE_CAPT_TOP;
      ctrl[CTRL_CS_LSB +: 3] = (i < 5) ? CS_DIV1 + 3'(i) : CS_DIV1;
      ctrl[CTRL_ACTB_LSB +: 2] = (i < 5) ? ACT_NONINV : (i == 7) ? ACT_INV : 2'(i);
      ctrl[CTRL_DIRB_BIT] = (i < 8) ? 1'h1 : 1'($random(seed));
      ctrl[CTRL_PRTB_BIT] = 1'($random(seed));
      wr(OFF_CMPB, 32'(c), RESP_OKAY);
      wr(OFF_CTRL, {16'h0, ctrl}, RESP_OKAY);
      idle(36 * nd + 20);
      meas(1'h1, 2 * TOPB * nd, hi_b(ctrl, c, nd));
    end
    $display("test pwm table done");
    wr(OFF_CMPB, 32'h4, RESP_OKAY);
    wr(OFF_CTRL, 32'h2818, RESP_OKAY);
    idle(40);
    wr(OFF_CLR, 32'hf, RESP_OKAY);
    idle(40);
    rd(OFF_STAT, 35'hf, 35'h60000000f);
    wr(OFF_CMPB, 32'ha, RESP_OKAY);
    idle(40);
    wr(OFF_CLR, 32'hf, RESP_OKAY);
    idle(40);
    rd(OFF_STAT, 35'h0, 35'h600000004);
    wr(OFF_IEN, 32'h1, RESP_OKAY);
    rd(OFF_STAT, 35'h100000000, 35'h700000000);
    wr(OFF_IEN, 32'h4, RESP_OKAY);
    rd(OFF_STAT, 35'h0, 35'h700000000);
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    idle(4);
    wr(OFF_CLR, 32'hf, RESP_OKAY);
    wr(OFF_IEN, 32'hf, RESP_OKAY);
    rd(OFF_STAT, 35'h0, M_ALL);
    $display("test flags and interrupt done");
    close_out();
  end
endmodule

bind pfpwm_timer pfpwm_timer_properties u_props (
  .CLK(CLK), .SRST(SRST), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
  .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ), .PIN_A_OE_N(PIN_A_OE_N),
  .PIN_B_OE_N(PIN_B_OE_N)
);
